// ==== fdr_pkg.sv ====
// Functional notes
// - output control register is write-only at index 2; cleared by master reset pin.
// - output control bit 4 drives the motor enable for drive A.
// - output control bit 3 enables the DMA and interrupt request outputs.
// - output control bit 2 low holds the controller core in reset.
// - output control bits 1-0 select drive A, B, C or D in binary.
// - tape register read at index 3; normal mode only bits 1-0, reset zero.
// - three-mode: tape bits 7-6 mirror media/boot config bits 5-4.
// - three-mode: tape bits 5-4 give drive type of last selected drive.
// - three-mode: tape bits 3-2 mirror config bits 7-6; reset pattern 0x30.
// - tape select 00 none, 01-11 drive 1-3; drive 0 never the tape drive.
// - status read at index 4; bit 7 ready for master, resets zero.
// - status bit 6 gives transfer direction, one means toward the processor.
// - status bit 5 set only in execution phase of a non-DMA command.
// - status bit 4 high while a read or write command is in progress.
// - status bits 3-0 high while the matching drive is seeking.
package fdr_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam int REG_W = 8;
   localparam int IDX_W = 4;
   localparam int LSB_W = 2;
   // register indices; the byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_DIGITAL_OUTPUT_CTRL = 4'h2;
   localparam logic [IDX_W-1:0] IDX_TAPE_DRIVE_ASSIGN = 4'h3;
   localparam logic [IDX_W-1:0] IDX_MAIN_TRANSFER_STATUS = 4'h4;
   localparam logic [IDX_W-1:0] IDX_FLOPPY_MODE_CONFIG = 4'h8;
   localparam logic [IDX_W-1:0] IDX_FLOPPY_MEDIA_BOOT_CONFIG = 4'h9;
   localparam logic [IDX_W-1:0] IDX_FLOPPY_DRIVE_TYPE_CONFIG = 4'ha;
   // output control fields
   localparam int DO_MOTOR_A = 4;
   localparam int DO_DMA_INT_EN = 3;
   localparam int DO_CORE_RESET_N = 2;
   localparam logic [REG_W-1:0] DO_WRITE_MASK = 8'h1f;
   localparam logic [REG_W-1:0] DO_RESET = 8'h00;
   localparam int DO_SEL_HI = 1;
   // configuration fields
   localparam int MODE_CFG_THREE_MODE = 0;
   localparam logic [REG_W-1:0] MODE_CFG_MASK = 8'h01;
   localparam logic [REG_W-1:0] MODE_CFG_RESET = 8'h00;
   localparam int MEDIA_HI = 5;
   localparam int MEDIA_LO = 4;
   localparam int BOOT_HI = 7;
   localparam int BOOT_LO = 6;
   localparam logic [REG_W-1:0] MEDIA_BOOT_RESET = 8'h00;
   localparam logic [REG_W-1:0] DRIVE_TYPE_RESET = 8'hff;
   localparam logic [1:0] TAPE_SEL_RESET = 2'h0;
   localparam int TAPE_SEL_HI = 1;
   // drive 0 is kept for booting, so its mask bit is never set
   localparam logic [3:0] TAPE_ALLOWED_MASK = 4'he;
   localparam logic [REG_W-1:0] STATUS_RESET = 8'h00;
   localparam logic [3:0] ONEHOT_RESET = 4'h0;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   function automatic logic [3:0] fdr_onehot(input logic [1:0] sel);
      fdr_onehot = 4'h1 << sel;
   endfunction

   function automatic logic [1:0] fdr_drive_type(input logic [REG_W-1:0] cfg,
                                                 input logic [1:0] sel);
      fdr_drive_type = cfg[{sel, 1'b0} +: 2];
   endfunction
endpackage

// ==== fdr_sync.sv ====
`timescale 1ns/10ps
module fdr_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic async_in,
   output logic sync_out
);
   import fdr_pkg::*;

   logic stage1;

   // first stage feeds only the second
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// ==== fdr_req_gate.sv ====
`timescale 1ns/10ps
module fdr_req_gate (
   input wire logic aclk,
   input wire logic clear,
   input wire logic enable,
   input wire logic drq_req,
   input wire logic irq_req,
   output logic drq_out,
   output logic irq_out
);
   import fdr_pkg::*;

   wire gated_drq = enable & drq_req;
   wire gated_irq = enable & irq_req;

   // one register stage so both requests leave from flops
   always_ff @(posedge aclk) begin
      if (clear) begin
         drq_out <= 1'b0;
         irq_out <= 1'b0;
      end else begin
         drq_out <= gated_drq;
         irq_out <= gated_irq;
      end
   end
endmodule

// ==== fdr_regs.sv ====
`timescale 1ns/10ps
module fdr_regs (
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [fdr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [fdr_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [fdr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [fdr_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // master reset pin, asynchronous to aclk
   input wire logic master_reset_pin,
   // controller core state, same clock
   input wire logic core_drq_req,
   input wire logic core_irq_req,
   input wire logic core_ready_for_master,
   input wire logic core_transfer_direction,
   input wire logic core_exec_phase,
   input wire logic core_nondma_mode,
   input wire logic core_command_busy,
   input wire logic drive3_seek_busy,
   input wire logic drive2_seek_busy,
   input wire logic drive1_seek_busy,
   input wire logic drive0_seek_busy,
   // controls toward the core and the drives
   output logic motor_a_enable,
   output logic [1:0] drive_select,
   output logic [3:0] drive_select_onehot,
   output logic floppy_controller_core_reset_n,
   output logic three_mode_enable,
   output logic [1:0] tape_drive_number,
   output logic [3:0] tape_drive_mask,
   output logic drq_out,
   output logic irq_out
);
   import fdr_pkg::*;

   // master reset pin crossing
   logic mr_sync;

   fdr_sync i_fdr_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .async_in(master_reset_pin),
      .sync_out(mr_sync)
   );

   // either reset source clears the device registers and request outputs; the bus channel flops reset on aresetn only
   wire clear = !aresetn | mr_sync;

   // register storage
   logic [REG_W-1:0] digital_output_ctrl;
   logic [1:0] tape_sel;
   logic [REG_W-1:0] main_transfer_status;
   logic [REG_W-1:0] floppy_mode_config;
   logic [REG_W-1:0] floppy_media_boot_config;
   logic [REG_W-1:0] floppy_drive_type_config;

   // write channel state
   logic aw_held;
   logic w_held;
   logic [IDX_W-1:0] wr_idx;
   logic [REG_W-1:0] wr_byte;
   logic wr_lane0;

   // read channel state
   logic [REG_W-1:0] rd_byte_q;

   // handshakes
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire ar_take = s_axi_arvalid & s_axi_arready;
   wire b_done = s_axi_bvalid & s_axi_bready;
   wire r_done = s_axi_rvalid & s_axi_rready;

   // a write commits in the first cycle that both halves are held and no answer is pending
   wire do_write = aw_held & w_held & !s_axi_bvalid;

   wire next_aw_held = !do_write & (aw_held | aw_take);
   wire next_w_held = !do_write & (w_held | w_take);
   wire next_bvalid = do_write | (s_axi_bvalid & !b_done);
   wire next_rvalid = ar_take | (s_axi_rvalid & !r_done);

   // address decode of the held write
   wire wr_hit_do = wr_idx == IDX_DIGITAL_OUTPUT_CTRL;
   wire wr_hit_td = wr_idx == IDX_TAPE_DRIVE_ASSIGN;
   wire wr_hit_ms = wr_idx == IDX_MAIN_TRANSFER_STATUS;
   wire wr_hit_mode = wr_idx == IDX_FLOPPY_MODE_CONFIG;
   wire wr_hit_media = wr_idx == IDX_FLOPPY_MEDIA_BOOT_CONFIG;
   wire wr_hit_dtype = wr_idx == IDX_FLOPPY_DRIVE_TYPE_CONFIG;
   wire wr_mapped = wr_hit_do | wr_hit_td | wr_hit_ms | wr_hit_mode
                  | wr_hit_media | wr_hit_dtype;

   // status register is read-only; a write to it is acknowledged and dropped
   wire wr_en = do_write & wr_lane0;
   wire we_do = wr_en & wr_hit_do;
   wire we_td = wr_en & wr_hit_td;
   wire we_mode = wr_en & wr_hit_mode;
   wire we_media = wr_en & wr_hit_media;
   wire we_dtype = wr_en & wr_hit_dtype;

   // reserved bits never reach the register
   wire [REG_W-1:0] next_do = wr_byte & DO_WRITE_MASK;
   wire [REG_W-1:0] next_mode = wr_byte & MODE_CFG_MASK;

   // address decode of the read request
   wire [IDX_W-1:0] rd_idx = s_axi_araddr[LSB_W +: IDX_W];
   wire rd_hit_do = rd_idx == IDX_DIGITAL_OUTPUT_CTRL;
   wire rd_hit_td = rd_idx == IDX_TAPE_DRIVE_ASSIGN;
   wire rd_hit_ms = rd_idx == IDX_MAIN_TRANSFER_STATUS;
   wire rd_hit_mode = rd_idx == IDX_FLOPPY_MODE_CONFIG;
   wire rd_hit_media = rd_idx == IDX_FLOPPY_MEDIA_BOOT_CONFIG;
   wire rd_hit_dtype = rd_idx == IDX_FLOPPY_DRIVE_TYPE_CONFIG;
   wire rd_mapped = rd_hit_do | rd_hit_td | rd_hit_ms | rd_hit_mode
                  | rd_hit_media | rd_hit_dtype;

   // output control and mode config fields
   wire [1:0] sel_field = digital_output_ctrl[DO_SEL_HI:0];
   wire three_mode = floppy_mode_config[MODE_CFG_THREE_MODE];

   // tape register views
   wire [1:0] media_id = {floppy_media_boot_config[MEDIA_HI],
                          floppy_media_boot_config[MEDIA_LO]};
   wire [1:0] boot_drive = {floppy_media_boot_config[BOOT_HI],
                            floppy_media_boot_config[BOOT_LO]};
   // drive type follows the drive currently held in the select field
   wire [1:0] drive_type = fdr_drive_type(floppy_drive_type_config, sel_field);
   wire [REG_W-1:0] td_three = {media_id, drive_type, boot_drive, tape_sel};
   wire [REG_W-1:0] td_normal = {6'h00, tape_sel};
   wire [REG_W-1:0] td_view = three_mode ? td_three : td_normal;

   // drive 0 is kept out of the tape mask
   wire [3:0] tape_decode = fdr_onehot(tape_sel);
   wire [3:0] next_tape_mask = tape_decode & TAPE_ALLOWED_MASK;

   // main status is sampled each cycle from the core
   wire nondma_exec = core_exec_phase & core_nondma_mode;
   wire [REG_W-1:0] next_status = {core_ready_for_master,
                                   core_transfer_direction,
                                   nondma_exec,
                                   core_command_busy,
                                   drive3_seek_busy,
                                   drive2_seek_busy,
                                   drive1_seek_busy,
                                   drive0_seek_busy};

   // read data selection; the output control register is write-only
   wire [REG_W-1:0] rd_byte =
      rd_hit_td ? td_view :
      rd_hit_ms ? main_transfer_status :
      rd_hit_mode ? floppy_mode_config :
      rd_hit_media ? floppy_media_boot_config :
      rd_hit_dtype ? floppy_drive_type_config :
      8'h00;

   // write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         s_axi_bvalid <= next_bvalid;
         s_axi_awready <= !next_aw_held & !next_bvalid;
         s_axi_wready <= !next_w_held & !next_bvalid;
      end
   end

   // held write payload
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_idx <= 4'h0;
         wr_byte <= 8'h00;
         wr_lane0 <= 1'b0;
      end else begin
         if (aw_take) begin
            wr_idx <= s_axi_awaddr[LSB_W +: IDX_W];
         end
         if (w_take) begin
            wr_byte <= s_axi_wdata[REG_W-1:0];
            wr_lane0 <= s_axi_wstrb[0];
         end
      end
   end

   // write answer is fixed when the write commits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // read channel; data are caught at the address handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b0;
         s_axi_rresp <= RESP_OKAY;
         rd_byte_q <= 8'h00;
      end else begin
         s_axi_rvalid <= next_rvalid;
         s_axi_arready <= !next_rvalid;
         if (ar_take) begin
            rd_byte_q <= rd_byte;
            s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
         end
      end
   end

   assign s_axi_rdata = {{(DATA_W-REG_W){1'b0}}, rd_byte_q};

   // output control register
   always_ff @(posedge aclk) begin
      if (clear) begin
         digital_output_ctrl <= DO_RESET;
      end else if (we_do) begin
         digital_output_ctrl <= next_do;
      end
   end

   // tape select and configuration registers
   always_ff @(posedge aclk) begin
      if (clear) begin
         tape_sel <= TAPE_SEL_RESET;
         floppy_mode_config <= MODE_CFG_RESET;
         floppy_media_boot_config <= MEDIA_BOOT_RESET;
         floppy_drive_type_config <= DRIVE_TYPE_RESET;
      end else begin
         if (we_td) begin
            tape_sel <= wr_byte[TAPE_SEL_HI:0];
         end
         if (we_mode) begin
            floppy_mode_config <= next_mode;
         end
         if (we_media) begin
            floppy_media_boot_config <= wr_byte;
         end
         if (we_dtype) begin
            floppy_drive_type_config <= wr_byte;
         end
      end
   end

   // status sample; holds zero through reset
   always_ff @(posedge aclk) begin
      if (clear) begin
         main_transfer_status <= STATUS_RESET;
      end else begin
         main_transfer_status <= next_status;
      end
   end

   // registered decodes for the drive-side outputs
   always_ff @(posedge aclk) begin
      if (clear) begin
         drive_select_onehot <= ONEHOT_RESET;
         tape_drive_mask <= ONEHOT_RESET;
      end else begin
         drive_select_onehot <= fdr_onehot(sel_field);
         tape_drive_mask <= next_tape_mask;
      end
   end

   // direct register bits; the core reset follows the control bit level
   assign motor_a_enable = digital_output_ctrl[DO_MOTOR_A];
   assign floppy_controller_core_reset_n = digital_output_ctrl[DO_CORE_RESET_N];
   assign drive_select = sel_field;
   assign three_mode_enable = three_mode;
   assign tape_drive_number = tape_sel;

   // request outputs lag the core requests by one cycle
   fdr_req_gate i_fdr_req_gate (
      .aclk(aclk),
      .clear(clear),
      .enable(digital_output_ctrl[DO_DMA_INT_EN]),
      .drq_req(core_drq_req),
      .irq_req(core_irq_req),
      .drq_out(drq_out),
      .irq_out(irq_out)
   );
endmodule

// ==== fdr_core_model.sv ====
`timescale 1ns/10ps
module fdr_core_model (
   input wire logic aclk,
   input wire logic floppy_controller_core_reset_n,
   input wire logic [10:0] want,
   output logic core_drq_req,
   output logic core_irq_req,
   output logic core_ready_for_master,
   output logic core_transfer_direction,
   output logic core_exec_phase,
   output logic core_nondma_mode,
   output logic core_command_busy,
   output logic drive3_seek_busy,
   output logic drive2_seek_busy,
   output logic drive1_seek_busy,
   output logic drive0_seek_busy
);
   // a core held in reset shows no requests and no busy state
   always_ff @(posedge aclk) begin
      {core_drq_req, core_irq_req, core_ready_for_master, core_transfer_direction,
       core_exec_phase, core_nondma_mode, core_command_busy, drive3_seek_busy,
       drive2_seek_busy, drive1_seek_busy, drive0_seek_busy} <=
         floppy_controller_core_reset_n ? want : 11'h000;
   end
endmodule

// ==== fdr_regs_monitor.sv ====
`timescale 1ns/10ps
module fdr_regs_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [fdr_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [fdr_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic master_reset_pin,
   input wire logic core_drq_req,
   input wire logic core_irq_req,
   input wire logic motor_a_enable,
   input wire logic [1:0] drive_select,
   input wire logic [3:0] drive_select_onehot,
   input wire logic floppy_controller_core_reset_n,
   input wire logic three_mode_enable,
   input wire logic [1:0] tape_drive_number,
   input wire logic [3:0] tape_drive_mask,
   input wire logic drq_out,
   input wire logic irq_out
);
   import fdr_pkg::*;
   // the pin goes through a synchroniser, so derived flops lag it by a few edges
   logic [5:0] mr_sh;
   always_ff @(posedge aclk) begin
      if (!aresetn) mr_sh <= '0;
      else mr_sh <= {mr_sh[4:0], master_reset_pin};
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_wr_both;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_take(logic [3:0] idx);
      s_axi_arvalid && s_axi_arready && s_axi_araddr[5:2] == idx;
   endsequence
   a_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
      else $error("write response missing");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_ctrl_reads_zero: assert property (s_rd_take(IDX_DIGITAL_OUTPUT_CTRL) |=>
      s_axi_rvalid && s_axi_rdata == 32'h0) else $error("control not write-only");
   a_tape_normal: assert property (s_rd_take(IDX_TAPE_DRIVE_ASSIGN) ##0 !three_mode_enable
      |=> s_axi_rdata == {30'h0, $past(tape_drive_number)}) else $error("tape read bad");
   a_drq_gate: assert property (drq_out |-> $past(core_drq_req))
      else $error("dma request without cause");
   a_irq_gate: assert property (irq_out |-> $past(core_irq_req))
      else $error("interrupt without cause");
   a_sel_onehot: assert property (disable iff (!aresetn || master_reset_pin || |mr_sh)
      $past(aresetn) |-> drive_select_onehot == 4'h1 << $past(drive_select))
      else $error("drive one-hot wrong");
   a_tape_mask: assert property (disable iff (!aresetn || master_reset_pin || |mr_sh)
      $past(aresetn) |-> tape_drive_mask == ($past(tape_drive_number) == 2'h0 ? 4'h0 :
      4'h1 << $past(tape_drive_number))) else $error("tape mask wrong");
   a_mr_clear: assert property (master_reset_pin [*4] |-> !motor_a_enable &&
      !floppy_controller_core_reset_n && drive_select == 2'h0 && tape_drive_number == 2'h0)
      else $error("master reset did not clear");
endmodule
bind fdr_regs fdr_regs_monitor i_fdr_regs_monitor (.aclk, .aresetn, .s_axi_awvalid,
   .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
   .master_reset_pin, .core_drq_req, .core_irq_req, .motor_a_enable, .drive_select,
   .drive_select_onehot, .floppy_controller_core_reset_n, .three_mode_enable,
   .tape_drive_number, .tape_drive_mask, .drq_out, .irq_out);

// ==== tb_top.sv ====
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", n, e, s); end end
module tb_top;
   import fdr_pkg::*;
   logic aclk, aresetn, master_reset_pin;
   logic [5:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, drive_select_onehot, tape_drive_mask;
   logic [1:0] s_axi_bresp, s_axi_rresp, drive_select, tape_drive_number;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic core_drq_req, core_irq_req, core_ready_for_master, core_transfer_direction;
   logic core_exec_phase, core_nondma_mode, core_command_busy;
   logic drive3_seek_busy, drive2_seek_busy, drive1_seek_busy, drive0_seek_busy;
   logic motor_a_enable, floppy_controller_core_reset_n, three_mode_enable, drq_out, irq_out;
   logic [10:0] want;
   logic [1:0] last_bresp;
   // when set, bready/rready wait for valid so the hold of each answer is exercised
   logic lazy = 1'b0;
   int error_cnt = 0;
   int n_tests = 0;
   fdr_regs i_fdr_regs (.*);
   fdr_core_model i_fdr_core_model (.*);
   initial begin
      aclk = 1'b0;
      forever #10 aclk = ~aclk;
   end
   task automatic settle;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !lazy;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
      end while (!(s_axi_bvalid && s_axi_bready));
      last_bresp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !lazy;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rdx(input logic [5:0] a, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a, d, r);
      `CHK("read data", {24'h0, e}, d)
   endtask
   task automatic t_reset;
      logic [31:0] d;
      logic [1:0] r;
      `CHK("motor", 1'b0, motor_a_enable)
      `CHK("core run", 1'b0, floppy_controller_core_reset_n)
      rdx(6'h08, 8'h00);
      rdx(6'h0c, 8'h00);
      rdx(6'h10, 8'h00);
      wr(6'h20, 8'h01);
      `CHK("mapped wr resp", RESP_OKAY, last_bresp)
      rdx(6'h0c, 8'h30);
      wr(6'h20, 8'h00);
      rd(6'h3c, d, r);
      `CHK("unmapped resp", RESP_SLVERR, r)
      wr(6'h3c, 8'h00);
      `CHK("unmapped wr resp", RESP_SLVERR, last_bresp)
   endtask
   task automatic t_ctrl;
      for (int s = 0; s < 4; s++) begin
         wr(6'h08, {5'b10101, s[1:0]});
         settle();
         `CHK("select", s[1:0], drive_select)
         `CHK("one-hot", 4'h1 << s, drive_select_onehot)
         `CHK("motor on", 1'b1, motor_a_enable)
         `CHK("core run", 1'b1, floppy_controller_core_reset_n)
      end
      // reserved bits set alongside a plain value must change nothing
      wr(6'h08, 8'he4);
      settle();
      `CHK("motor off", 1'b0, motor_a_enable)
      `CHK("select", 2'h0, drive_select)
      rdx(6'h08, 8'h00);
      wr(6'h08, 8'h00);
      settle();
      `CHK("core held", 1'b0, floppy_controller_core_reset_n)
   endtask
   task automatic t_req;
      wr(6'h08, 8'h0c);
      @(posedge aclk);
      want <= 11'h600;
      settle();
      `CHK("dma req", 1'b1, drq_out)
      `CHK("int req", 1'b1, irq_out)
      wr(6'h08, 8'h04);
      settle();
      `CHK("dma gated", 1'b0, drq_out)
      `CHK("int gated", 1'b0, irq_out)
   endtask
   task automatic t_status;
      logic [8:0] pats [4] = '{9'h1c5, 9'h07a, 9'h020, 9'h10f};
      lazy = 1'b1;
      foreach (pats[i]) begin
         @(posedge aclk);
         want <= {2'b00, pats[i]};
         repeat (3) @(posedge aclk);
         rdx(6'h10, {pats[i][8:7], pats[i][6] & pats[i][5], pats[i][4:0]});
      end
      lazy = 1'b0;
   endtask
   task automatic t_tape;
      for (int t = 0; t < 4; t++) begin
         wr(6'h0c, t[7:0]);
         rdx(6'h0c, t[7:0]);
         `CHK("tape mask", t == 0 ? 4'h0 : 4'h1 << t, tape_drive_mask)
      end
      wr(6'h20, 8'h01);
      `CHK("three mode", 1'b1, three_mode_enable)
      wr(6'h24, 8'hb0);
      wr(6'h28, 8'he4);
      wr(6'h0c, 8'h02);
      for (int s = 0; s < 4; s++) begin
         wr(6'h08, {6'b000001, s[1:0]});
         rdx(6'h0c, {2'b11, s[1:0], 4'b1010});
      end
      wr(6'h20, 8'h00);
   endtask
   task automatic t_mr;
      wr(6'h08, 8'h1f);
      wr(6'h0c, 8'h03);
      @(posedge aclk);
      master_reset_pin <= 1'b1;
      repeat (5) @(posedge aclk);
      @(negedge aclk);
      `CHK("motor cleared", 1'b0, motor_a_enable)
      `CHK("core cleared", 1'b0, floppy_controller_core_reset_n)
      `CHK("tape cleared", 2'h0, tape_drive_number)
      @(posedge aclk);
      master_reset_pin <= 1'b0;
      repeat (8) @(posedge aclk);
      rdx(6'h0c, 8'h00);
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      {aresetn, master_reset_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awprot, s_axi_arprot, want} = '0;
      s_axi_wstrb = 4'h1;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_ctrl();
      t_req();
      t_status();
      t_tape();
      t_mr();
      report_and_stop();
   end
endmodule
